// [logic/mrc_pkg.sv]
// constants of the mode and reset control block
// Contract
// - a zero to one change of the start bit begins the connection memory block fill; the code does so only with the block programming enable set.
// - the fill takes a number of frames, then the device clears the start bit.
// - completion is reported by the start bit returning low after the fill.
// - clearing the start bit or the block programming enable while filling aborts the fill.
// - switch soft reset bit 1 high holds the switching blocks in reset.
// - pll soft reset bit 0 high holds the clock recovery block in reset.
// - with the upper bidirectional bit set, inputs of streams 16 to 31 are forced low.
package mrc_pkg;
    localparam logic [3:0] MRC_IDX_MODE = 4'h1;
    localparam logic [3:0] MRC_IDX_OUTEN = 4'h3;
    localparam logic [3:0] MRC_IDX_SRST = 4'h4;
    localparam logic [3:0] MRC_IDX_CTRL = 4'h5;
    localparam logic [3:0] MRC_IDX_STAT = 4'h6;
    localparam logic [15:0] MRC_MODE_RST = 16'h0000;
    localparam logic [15:0] MRC_OUTEN_RST = 16'h0000;
    localparam logic [15:0] MRC_SRST_RST = 16'h0000;
    localparam logic [15:0] MRC_CTRL_RST = 16'h0000;
    localparam logic [15:0] MRC_MODE_MASK = 16'h01FF;
    localparam logic [15:0] MRC_OUTEN_MASK = 16'h01FF;
    localparam logic [15:0] MRC_SRST_MASK = 16'h0003;
    localparam int MRC_B_START = 0;
    localparam int MRC_B_PAT = 1;
    localparam int MRC_B_TXERR = 4;
    localparam int MRC_B_RXERR = 5;
    localparam int MRC_B_BIDL = 6;
    localparam int MRC_B_BIDH = 7;
    localparam int MRC_B_PDEN = 8;
    localparam int MRC_B_PLLRST = 0;
    localparam int MRC_B_SWRST = 1;
    localparam int MRC_B_BPEN = 0;
    localparam int MRC_CM_AW = 11;
    localparam int MRC_CM_DW = 16;
    localparam logic [10:0] MRC_CM_LAST = 11'h7FF;
    localparam int MRC_FRAME_NS = 125000;
    localparam int MRC_CLK_NS = 5;
    localparam int MRC_FRAME_CYC = MRC_FRAME_NS / MRC_CLK_NS;
    localparam logic [2:0] MRC_FILL_FRAMES = 3'h2;
    localparam logic [1:0] MRC_HTRANS_NONSEQ = 2'h2;
    typedef enum logic [1:0] {MRC_IDLE = 2'b00, MRC_FILL = 2'b01, MRC_WAIT = 2'b11} mrc_state_t;
endpackage

// [logic/mrc_ctrl.sv]
// mode, soft reset and block fill registers behind an ahb-lite slave
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mrc_ctrl
    import mrc_pkg::*;
#(
    parameter int FRAME_CYC = MRC_FRAME_CYC
)(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [31:0] stream_in_pins,
    output logic [31:0] stream_in,
    output logic switch_soft_reset,
    output logic pll_soft_reset,
    output logic [31:0] error_test_rx_enable,
    output logic [31:0] error_test_tx_enable,
    input wire logic [31:0] rx_stream_err_en,
    input wire logic [31:0] tx_stream_err_en,
    output logic bidir_upper_streams,
    output logic bidir_lower_streams,
    output logic stream_pulldown_enable,
    output logic [8:0] clock_pulse_output_enables,
    output logic cm_we,
    output logic [MRC_CM_AW-1:0] cm_addr,
    output logic [MRC_CM_DW-1:0] cm_wdata
);
    typedef struct packed {
        logic [15:0] mode;
        logic [15:0] outen;
        logic [15:0] srst;
        logic [15:0] ctrl;
        mrc_state_t st;
        logic [MRC_CM_AW-1:0] addr;
        logic we;
        logic [17:0] fcnt;
        logic [2:0] frames;
        logic wr;
        logic [3:0] idx;
        logic [31:0] rdata;
        logic [31:0] s1;
        logic [31:0] s2;
        logic [31:0] s3;
        logic [31:0] sf;
    } mrc_regs_t;

    mrc_regs_t r_q;
    mrc_regs_t r_d;
    logic take;
    logic [15:0] wv;
    logic [15:0] new_mode;
    logic abort;
    logic frame_tick;

    assign take = hsel && hready && (htrans == MRC_HTRANS_NONSEQ);
    assign wv = hwdata[15:0];
    assign frame_tick = (r_q.fcnt == 18'(FRAME_CYC - 1));

    always_comb
    begin
        r_d = r_q;
        r_d.we = 1'b0;
        new_mode = r_q.mode;
        abort = 1'b0;
        r_d.s1 = stream_in_pins;
        r_d.s2 = r_q.s1;
        r_d.s3 = r_q.s2;
        // a pin bit moves only once the second and third stages agree
        r_d.sf = (r_q.s3 & ~(r_q.s2 ^ r_q.s3)) | (r_q.sf & (r_q.s2 ^ r_q.s3));
        // bus data phase
        if (r_q.wr)
        begin
            unique case (r_q.idx)
                MRC_IDX_MODE: new_mode = wv & MRC_MODE_MASK;
                MRC_IDX_OUTEN: r_d.outen = wv & MRC_OUTEN_MASK;
                MRC_IDX_SRST: r_d.srst = wv & MRC_SRST_MASK;
                MRC_IDX_CTRL: r_d.ctrl = {15'h0000, wv[MRC_B_BPEN]};
                default: ;
            endcase
        end
        if (r_q.st != MRC_IDLE)
        begin
            abort = !new_mode[MRC_B_START] || !r_d.ctrl[MRC_B_BPEN];
        end
        r_d.mode = new_mode;
        unique case (r_q.st)
            MRC_IDLE:
            begin
                if (!r_q.mode[MRC_B_START] && new_mode[MRC_B_START]
                    && r_d.ctrl[MRC_B_BPEN])
                begin
                    r_d.st = MRC_FILL;
                    r_d.addr = '0;
                end
                else if (!r_d.ctrl[MRC_B_BPEN])
                begin
                    r_d.mode[MRC_B_START] = 1'b0;
                end
            end
            MRC_FILL:
            begin
                if (abort)
                begin
                    r_d.st = MRC_IDLE;
                    r_d.mode[MRC_B_START] = 1'b0;
                end
                else
                begin
                    r_d.we = 1'b1;
                    r_d.addr = r_q.addr + 11'h001;
                    if (r_q.addr == MRC_CM_LAST)
                    begin
                        r_d.st = MRC_WAIT;
                        r_d.frames = '0;
                    end
                end
            end
            MRC_WAIT:
            begin
                if (abort)
                begin
                    r_d.st = MRC_IDLE;
                    r_d.mode[MRC_B_START] = 1'b0;
                end
                else if (frame_tick)
                begin
                    r_d.frames = r_q.frames + 3'h1;
                    if (r_q.frames == MRC_FILL_FRAMES - 3'h1)
                    begin
                        r_d.st = MRC_IDLE;
                        r_d.mode[MRC_B_START] = 1'b0;
                    end
                end
            end
            default: r_d.st = MRC_IDLE;
        endcase
        r_d.fcnt = frame_tick ? 18'h00000 : r_q.fcnt + 18'h00001;
        r_d.wr = take && hwrite;
        r_d.idx = haddr[5:2];
        if (take && !hwrite)
        begin
            unique case (haddr[5:2])
                MRC_IDX_MODE: r_d.rdata = {16'h0000, r_d.mode};
                MRC_IDX_OUTEN: r_d.rdata = {16'h0000, r_d.outen};
                MRC_IDX_SRST: r_d.rdata = {16'h0000, r_d.srst};
                MRC_IDX_CTRL: r_d.rdata = {16'h0000, r_d.ctrl};
                MRC_IDX_STAT: r_d.rdata = {30'h00000000, r_q.st};
                default: r_d.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r_q <= '0;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign hrdata = r_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign switch_soft_reset = r_q.srst[MRC_B_SWRST];
    assign pll_soft_reset = r_q.srst[MRC_B_PLLRST];
    assign error_test_rx_enable = rx_stream_err_en & {32{r_q.mode[MRC_B_RXERR]}};
    assign error_test_tx_enable = tx_stream_err_en & {32{r_q.mode[MRC_B_TXERR]}};
    assign bidir_upper_streams = r_q.mode[MRC_B_BIDH];
    assign bidir_lower_streams = r_q.mode[MRC_B_BIDL];
    assign stream_pulldown_enable = r_q.mode[MRC_B_PDEN];
    assign clock_pulse_output_enables = r_q.outen[8:0];
    assign stream_in[31:16] = r_q.mode[MRC_B_BIDH] ? 16'h0000 : r_q.sf[31:16];
    assign stream_in[15:0] = r_q.mode[MRC_B_BIDL] ? 16'h0000 : r_q.sf[15:0];
    assign cm_we = r_q.we;
    assign cm_addr = r_q.addr - 11'h001;
    assign cm_wdata = {13'h0000, r_q.mode[3:1]};

    sequence s_fill_go;
        r_q.st == MRC_IDLE && r_d.st == MRC_FILL;
    endsequence
    sequence s_first_loc;
        (r_q.st == MRC_FILL && r_q.addr == 11'h000)
        ##1 ((cm_we && cm_addr == 11'h000) || r_q.st == MRC_IDLE);
    endsequence
    a_fill_start: assert property (@(posedge hclk) disable iff (!hresetn)
        s_fill_go |=> s_first_loc)
        else $error("fill did not start at location zero");
    a_no_restart: assert property (@(posedge hclk) disable iff (!hresetn)
        (r_q.st == MRC_IDLE && !(r_q.wr && r_q.idx == MRC_IDX_MODE)) |=> r_q.st == MRC_IDLE)
        else $error("fill started without a mode write");
    a_fill_step: assert property (@(posedge hclk) disable iff (!hresetn)
        (r_q.st == MRC_FILL && !abort && r_q.addr != MRC_CM_LAST)
        |=> r_q.st == MRC_FILL && r_q.addr == $past(r_q.addr) + 11'h001)
        else $error("fill address did not advance");
    a_we_active: assert property (@(posedge hclk) disable iff (!hresetn)
        cm_we |-> r_q.st != MRC_IDLE)
        else $error("memory write outside a fill");
    a_wait_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (r_q.st == MRC_WAIT && !abort && !frame_tick) |=> r_q.st == MRC_WAIT)
        else $error("frame wait left early");
    a_wait_count: assert property (@(posedge hclk) disable iff (!hresetn)
        r_q.st == MRC_WAIT |-> r_q.frames < MRC_FILL_FRAMES)
        else $error("frame count overran");
    a_frame_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
        r_q.fcnt < 18'(FRAME_CYC))
        else $error("frame counter out of range");
    a_fill_done: assert property (@(posedge hclk) disable iff (!hresetn)
        (r_q.st == MRC_WAIT && !abort && frame_tick && r_q.frames == MRC_FILL_FRAMES - 3'h1)
        |=> r_q.st == MRC_IDLE && !r_q.mode[MRC_B_START])
        else $error("fill did not finish after its frames");
    a_abort_mode: assert property (@(posedge hclk) disable iff (!hresetn)
        (r_q.st != MRC_IDLE && r_q.wr && r_q.idx == MRC_IDX_MODE && !hwdata[MRC_B_START])
        |=> r_q.st == MRC_IDLE && !r_q.mode[MRC_B_START])
        else $error("start clear did not abort");
    a_start_drop: assert property (@(posedge hclk) disable iff (!hresetn)
        (r_q.st == MRC_IDLE && r_q.wr && r_q.idx == MRC_IDX_MODE && !r_q.ctrl[MRC_B_BPEN])
        |=> r_q.st == MRC_IDLE && !r_q.mode[MRC_B_START])
        else $error("start accepted without enable");
    a_mode_mask: assert property (@(posedge hclk) disable iff (!hresetn)
        (r_q.wr && r_q.idx == MRC_IDX_MODE) |=> r_q.mode[15:9] == 7'h00)
        else $error("reserved mode bits set");
    a_srst_mask: assert property (@(posedge hclk) disable iff (!hresetn)
        (r_q.wr && r_q.idx == MRC_IDX_SRST) |=> r_q.srst[15:2] == 14'h0000)
        else $error("reserved soft reset bits set");
    a_stat_read: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && haddr[5:2] == MRC_IDX_STAT)
        |=> hrdata[31:2] == 30'h00000000 && hrdata[1:0] == $past(r_q.st))
        else $error("status read wrong");
    a_pin_filter: assert property (@(posedge hclk) disable iff (!hresetn)
        (r_q.s2 == r_q.s3) |=> r_q.sf == $past(r_q.s3))
        else $error("pin filter did not settle");
    a_lower_low: assert property (@(posedge hclk) disable iff (!hresetn)
        bidir_lower_streams |-> stream_in[15:0] == 16'h0000)
        else $error("lower streams not forced low");
    a_tx_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        !r_q.mode[MRC_B_TXERR] |-> error_test_tx_enable == 32'h00000000)
        else $error("tx error test not gated");
    a_done_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        (r_q.st == MRC_WAIT && r_d.st == MRC_IDLE) |=> !r_q.mode[MRC_B_START])
        else $error("start bit not cleared after fill");
    a_abort_fill: assert property (@(posedge hclk) disable iff (!hresetn)
        (r_q.st != MRC_IDLE && r_q.wr && r_q.idx == MRC_IDX_CTRL && !hwdata[MRC_B_BPEN])
        |=> r_q.st == MRC_IDLE && !r_q.mode[MRC_B_START])
        else $error("fill kept running without enable");
    a_pat_write: assert property (@(posedge hclk) disable iff (!hresetn)
        cm_we |-> cm_wdata[15:3] == 13'h0000 && cm_wdata[2:0] == r_q.mode[3:1])
        else $error("fill data wrong");
    a_sw_reset: assert property (@(posedge hclk) disable iff (!hresetn)
        (r_q.wr && r_q.idx == MRC_IDX_SRST) |=> switch_soft_reset == $past(hwdata[MRC_B_SWRST]))
        else $error("switch reset not following write");
    a_pll_reset: assert property (@(posedge hclk) disable iff (!hresetn)
        (r_q.wr && r_q.idx == MRC_IDX_SRST) |=> pll_soft_reset == $past(hwdata[MRC_B_PLLRST]))
        else $error("pll reset not following write");
    a_upper_low: assert property (@(posedge hclk) disable iff (!hresetn)
        bidir_upper_streams |-> stream_in[31:16] == 16'h0000)
        else $error("upper streams not forced low");
    a_rx_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        !r_q.mode[MRC_B_RXERR] |-> error_test_rx_enable == 32'h00000000 && error_test_tx_enable
        == (tx_stream_err_en & {32{r_q.mode[MRC_B_TXERR]}}))
        else $error("error test gating wrong");
    a_fill_len: assert property (@(posedge hclk) disable iff (!hresetn)
        (r_q.st == MRC_FILL && r_q.addr == MRC_CM_LAST && !abort) |=> r_q.st == MRC_WAIT)
        else $error("fill length wrong");
endmodule // mrc_ctrl
`default_nettype wire

// [test/mrc_ctrl_tb.sv]
// self-checking bench for the mode, soft reset and block fill registers
`timescale 1ns/1ps
`default_nettype none
module mrc_ctrl_tb;
    import mrc_pkg::*;
    localparam int FC = 8;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, stream_in, rx_o, tx_o, rd;
    logic hreadyout, hresp, sw_rst, pll_rst, bid_hi, bid_lo, pd_en, cm_we;
    logic [31:0] pins = 32'hA5C3_5A3C;
    logic [31:0] rx_in = 32'hFFFF_FFFF;
    logic [31:0] tx_in = 32'h0F0F_F0F0;
    logic [8:0] outen;
    logic [MRC_CM_AW-1:0] cm_addr;
    logic [MRC_CM_DW-1:0] cm_wdata;
    logic [2:0] pat = 3'h5;
    int errors = 0;
    int n_tests = 0;
    int n_we = 0;
    int snap;
    always #2.5 hclk = ~hclk;
    mrc_ctrl #(.FRAME_CYC(FC)) uut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .stream_in_pins(pins), .stream_in, .switch_soft_reset(sw_rst),
        .pll_soft_reset(pll_rst), .error_test_rx_enable(rx_o), .error_test_tx_enable(tx_o),
        .rx_stream_err_en(rx_in), .tx_stream_err_en(tx_in), .bidir_upper_streams(bid_hi),
        .bidir_lower_streams(bid_lo), .stream_pulldown_enable(pd_en),
        .clock_pulse_output_enables(outen), .cm_we, .cm_addr, .cm_wdata
    );
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= MRC_HTRANS_NONSEQ;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask
    task automatic conclude;
        if (errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // every fill write carries the pattern at the next address
    always @(posedge hclk)
    begin
        if (cm_we === 1'b1)
        begin
            chk("cm_addr", 32'(n_we), {21'h0, cm_addr});
            chk("cm_wdata", {29'h0, pat}, {16'h0, cm_wdata});
            n_we++;
        end
    end
    initial
    begin
        #100000;
        errors++;
        conclude();
    end
    initial
    begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 9; i++)
            rdc("reset read", 32'(i * 4), 32'h0);
        chk("hresp", 32'h0, {31'h0, hresp});
        wr(32'h10, 32'h0000_FFFF);
        rdc("srst", 32'h10, 32'h0000_0003);
        @(negedge hclk);
        chk("switch reset", 32'h1, {31'h0, sw_rst});
        chk("pll reset", 32'h1, {31'h0, pll_rst});
        wr(32'h10, 32'h0000_0001);
        @(negedge hclk);
        chk("switch reset", 32'h0, {31'h0, sw_rst});
        chk("pll reset", 32'h1, {31'h0, pll_rst});
        wr(32'h10, 32'h0000_0000);
        @(negedge hclk);
        chk("pll reset", 32'h0, {31'h0, pll_rst});
        wr(32'h04, 32'h0000_00A0);
        rdc("mode", 32'h04, 32'h0000_00A0);
        @(negedge hclk);
        chk("stream_in", {16'h0, pins[15:0]}, stream_in);
        chk("rx enable", rx_in, rx_o);
        chk("tx enable", 32'h0, tx_o);
        wr(32'h04, 32'h0000_FF50);
        rdc("mode", 32'h04, 32'h0000_0150);
        @(negedge hclk);
        chk("stream_in", {pins[31:16], 16'h0}, stream_in);
        chk("rx enable", 32'h0, rx_o);
        chk("tx enable", tx_in, tx_o);
        chk("pulldown", 32'h1, {31'h0, pd_en});
        wr(32'h0C, 32'h0000_FFFF);
        rdc("outen", 32'h0C, 32'h0000_01FF);
        chk("outen pins", 32'h0000_01FF, {23'h0, outen});
        wr(32'h04, 32'h0000_0000);
        wr(32'h14, 32'h0000_0001);
        wr(32'h04, {28'h0, pat, 1'b1});
        for (int k = 0; k < 3000 && n_we < 2048; k++)
            @(posedge hclk);
        rdc("fill waiting", 32'h04, {28'h0, pat, 1'b1});
        for (int k = 0; k < 100; k++)
        begin
            bus(1'b0, 32'h18, 32'h0);
            if (rd[1:0] === 2'h0)
                break;
        end
        chk("fill count", 32'd2048, 32'(n_we));
        rdc("fill done", 32'h04, {28'h0, pat, 1'b0});
        pat = 3'h1;
        n_we = 0;
        wr(32'h04, 32'h0000_0003);
        repeat (20) @(posedge hclk);
        wr(32'h04, 32'h0000_0002);
        rdc("abort start", 32'h04, 32'h0000_0002);
        snap = n_we;
        repeat (10) @(posedge hclk);
        chk("abort stops", 32'(snap), 32'(n_we));
        n_we = 0;
        wr(32'h04, 32'h0000_0003);
        repeat (20) @(posedge hclk);
        wr(32'h14, 32'h0000_0000);
        rdc("abort enable", 32'h04, 32'h0000_0002);
        snap = n_we;
        wr(32'h04, 32'h0000_0000);
        wr(32'h04, 32'h0000_0003);
        repeat (10) @(posedge hclk);
        chk("no fill", 32'(snap), 32'(n_we));
        rdc("start dropped", 32'h04, 32'h0000_0002);
        conclude();
    end
endmodule // mrc_ctrl_tb
`default_nettype wire
